//--- verilog/cgs_pkg.sv
/*
 * Constants, register map and field layout for the CCD gain-select and
 * output control block.
 * Assumes a single 100 MHz clock and a parallel register write/read port
 * fed by the serial configuration interface outside this block.
 */
// Overview of operation
// - Six gain registers: one master, three colour differences, two black differences.
// - Master gain register is ten bits and is the base for all gains.
// - Selected nine-bit colour difference is subtracted from master to form gain code.
// - Even and odd black differences set black-pixel gain during calibration.
// - Gain codes are a log scale, 0.047 dB per step.
// - Mode bit 0 picks progressive/interlaced, bit 1 picks sync or line-id parity.
// - In line-id modes each pre-blanking pulse latches the line-id level.
// - Progressive sync mode toggles the line-pattern flag on each pre-blanking pulse, unless frame sync rises in the same cycle.
// - In sync modes frame sync presets the line flag to the start parity bit.
// - Per pattern pixel a two-bit pointer picks one of four gain registers.
// - Two-bit length field per line type gives one to four pixels, default two.
// - Power-down when the pin is high or the chip sleep bit is set.
// - Power-down turns analog off and floats the twelve-bit output bus.
// - Power-down resets no register; the configuration port keeps working.
// - Two test bits separately power down front end and converter.
// - Bus drives only when enable bit is one and enable pin is low.
// - Output enable affects only the drivers; all other logic keeps running.
// - Power-on reset loads defaults into every register.
// - Writing the software reset bit resets the chip, then clears after 10 ns.
// - Reset pin low holds the chip in reset until it returns high.
// - With floor clip on, codes below the offset are replaced by the offset.
// - Floor clip acts only on the bus; calibration data stays unclipped.
// - With clamp on and pre-blanking active, the bus carries the offset code.
package cgs_pkg;

    localparam int MG_W   = 10;
    localparam int DIFF_W = 9;
    localparam int OFS_W  = 8;
    localparam int BUS_W  = 12;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 10;
    localparam int PAT_W  = 10;
    localparam int CTL_W  = 10;
    localparam int NPIN   = 6;

    // Register indices on the configuration port.
    localparam logic [ADDR_W-1:0] REG_MASTER_GAIN  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_DIFF_ONE     = 4'h1;
    localparam logic [ADDR_W-1:0] REG_DIFF_TWO     = 4'h2;
    localparam logic [ADDR_W-1:0] REG_DIFF_THREE   = 4'h3;
    localparam logic [ADDR_W-1:0] REG_BLACK_EVEN   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_BLACK_ODD    = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CONTROL      = 4'h6;
    localparam logic [ADDR_W-1:0] REG_EVEN_PATTERN = 4'h7;
    localparam logic [ADDR_W-1:0] REG_ODD_PATTERN  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_OFFSET       = 4'h9;
    localparam logic [ADDR_W-1:0] REG_RESET        = 4'ha;
    localparam logic [ADDR_W-1:0] REG_STATUS       = 4'hb;

    // Control register fields.
    localparam int CTL_CHIP_SLEEP  = 0;
    localparam int CTL_FE_SLEEP    = 1;
    localparam int CTL_CONV_SLEEP  = 2;
    localparam int CTL_OUT_EN      = 3;
    localparam int CTL_FLOOR_CLIP  = 4;
    localparam int CTL_OUT_CLAMP   = 5;
    localparam int CTL_MODE_LSB    = 6;
    localparam int CTL_START_PAR   = 8;
    localparam int CTL_MULT_GAIN   = 9;
    localparam int MODE_PROG_BIT   = 0;
    localparam int MODE_SYNC_BIT   = 1;

    // Pattern register fields: length then four pointers.
    localparam int PAT_LEN_LSB = 0;
    localparam int PAT_PTR_LSB = 2;

    // Status register fields.
    localparam int STS_LINE_SEL = 0;
    localparam int STS_SLEEPING = 1;
    localparam int STS_DRIVING  = 2;

    localparam int RST_BIT = 0;

    // Synchronised pin positions.
    localparam int PIN_PD    = 0;
    localparam int PIN_OE_N  = 1;
    localparam int PIN_LID   = 2;
    localparam int PIN_PREBLANK_STROBE  = 3;
    localparam int PIN_FSYNC = 4;
    localparam int PIN_CAL   = 5;

    // Reset values.
    localparam logic [MG_W-1:0]   MASTER_GAIN_RST = 10'h000;
    localparam logic [DIFF_W-1:0] DIFF_RST        = 9'h000;
    localparam logic [CTL_W-1:0]  CONTROL_RST     = 10'h038;
    localparam logic [PAT_W-1:0]  EVEN_PAT_RST    = 10'h005;
    localparam logic [PAT_W-1:0]  ODD_PAT_RST     = 10'h021;
    localparam logic [OFS_W-1:0]  OFFSET_RST      = 8'h00;

    // Self-clearing software reset: longest time, rounded down, at least one cycle.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SW_RST_NS     = 10;
    localparam int SW_RST_CYC    = (SW_RST_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : (SW_RST_NS / CLK_PERIOD_NS);
    localparam logic [3:0] SW_RST_CYC_V = 4'(SW_RST_CYC);

endpackage : cgs_pkg

//--- verilog/cgs_sync.sv
/*
 * Two-flop synchronisers, one per bit, for asynchronous pins.
 * Assumes nothing reads the first stage except the second stage.
 */
module cgs_sync
    import cgs_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                meta_reg[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_reg[i] <= async_in[i];
                sync_out[i] <= meta_reg[i];
            end
        end
    end

endmodule : cgs_sync

//--- verilog/cgs_gain_sel.sv
/*
 * Per-pixel gain code selection from master gain and difference registers.
 * Assumes one pixel per clock, the pattern restarting while pre-blanking is
 * active, and a calibration strobe that marks optical-black pixels.
 */
module cgs_gain_sel
    import cgs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              clr,
    input  wire logic              mult_gain_en,
    input  wire logic              line_sel,
    input  wire logic              preblank,
    input  wire logic              calib,
    input  wire logic [MG_W-1:0]   master_gain,
    input  wire logic [DIFF_W-1:0] gain_diff_one,
    input  wire logic [DIFF_W-1:0] gain_diff_two,
    input  wire logic [DIFF_W-1:0] gain_diff_three,
    input  wire logic [DIFF_W-1:0] black_gain_diff_even,
    input  wire logic [DIFF_W-1:0] black_gain_diff_odd,
    input  wire logic [PAT_W-1:0]  even_pattern,
    input  wire logic [PAT_W-1:0]  odd_pattern,
    output logic      [MG_W-1:0]   gain_code_reg
);

    logic [1:0]        pix_reg;
    logic [PAT_W-1:0]  pat;
    logic [1:0]        ptr;
    logic [DIFF_W-1:0] diff;
    logic [MG_W-1:0]   gain_next;

    assign pat = line_sel ? odd_pattern : even_pattern;

    always_ff @(posedge ref_clk) begin
        if (clr || preblank) begin
            pix_reg <= 2'h0;
        end else if (pix_reg == pat[PAT_LEN_LSB +: 2]) begin
            pix_reg <= 2'h0;
        end else begin
            pix_reg <= pix_reg + 2'h1;
        end
    end

    always_comb begin
        ptr = mult_gain_en ? pat[PAT_PTR_LSB + 2 * int'(pix_reg) +: 2] : 2'h0;
        case (ptr)
            2'h1:    diff = gain_diff_one;
            2'h2:    diff = gain_diff_two;
            2'h3:    diff = gain_diff_three;
            default: diff = DIFF_RST;
        endcase
        if (calib) begin
            diff = line_sel ? black_gain_diff_odd : black_gain_diff_even;
        end
        // Underflow saturates at the lowest gain rather than wrapping to the highest.
        gain_next = (master_gain >= {1'b0, diff}) ? master_gain - {1'b0, diff} : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            gain_code_reg <= MASTER_GAIN_RST;
        end else begin
            gain_code_reg <= gain_next;
        end
    end

    AST_MASTER_ONLY: assert property (@(posedge ref_clk) disable iff (clr)
        (!mult_gain_en && !calib) |=> gain_code_reg == $past(master_gain))
        else $error("gain code differs from master gain with pattern off");

endmodule : cgs_gain_sel

//--- verilog/cgs_ctrl.sv
/*
 * Top of the CCD gain-select and output control logic: register file,
 * line-pattern tracking, power-down, reset and output bus control.
 * Assumes converter data arrives on the ref_clk domain, and that the
 * serial interface outside delivers parallel register writes and reads.
 */
module cgs_ctrl
    import cgs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              reg_wr,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              powerdown_pin,
    input  wire logic              output_enable_n_pin,
    input  wire logic              line_id_input,
    input  wire logic              preblank_strobe,
    input  wire logic              frame_sync,
    input  wire logic              cal_strobe,
    input  wire logic [BUS_W-1:0]  adc_data,
    output logic      [BUS_W-1:0]  output_bus,
    output logic                   output_bus_oe_n,
    output logic      [BUS_W-1:0]  calib_data,
    output logic      [MG_W-1:0]   gain_code,
    output logic                   frontend_off,
    output logic                   converter_off
);

    logic [NPIN-1:0]   pin_s;
    logic              preblank_strobe_d_reg;
    logic              fs_d_reg;
    logic              preblank_strobe_rise;
    logic              fs_rise;
    logic              soft_rst_reg;
    logic [3:0]        soft_cnt_reg;
    logic              clr;
    logic [MG_W-1:0]   master_gain_reg;
    logic [DIFF_W-1:0] gain_diff_one_reg;
    logic [DIFF_W-1:0] gain_diff_two_reg;
    logic [DIFF_W-1:0] gain_diff_three_reg;
    logic [DIFF_W-1:0] black_gain_diff_even_reg;
    logic [DIFF_W-1:0] black_gain_diff_odd_reg;
    logic [CTL_W-1:0]  control_reg;
    logic [PAT_W-1:0]  even_pattern_reg;
    logic [PAT_W-1:0]  odd_pattern_reg;
    logic [OFS_W-1:0]  offset_code_reg;
    logic              line_sel_reg;
    logic [1:0]        line_parity_mode;
    logic              chip_sleep_bit;
    logic              sleeping;
    logic              drive_en;
    logic              clamp_now;
    logic [BUS_W-1:0]  offset_wide;
    logic [BUS_W-1:0]  bus_next;
    logic [DATA_W-1:0] rdata_next;

    cgs_sync #(.W(NPIN)) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({cal_strobe, frame_sync, preblank_strobe, line_id_input,
                    output_enable_n_pin, powerdown_pin}),
        .sync_out (pin_s)
    );

    // The reset pin and the power-on reset both arrive as rst_n.
    assign clr = !rst_n || soft_rst_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            preblank_strobe_d_reg <= 1'b0;
            fs_d_reg   <= 1'b0;
        end else begin
            preblank_strobe_d_reg <= pin_s[PIN_PREBLANK_STROBE];
            fs_d_reg   <= pin_s[PIN_FSYNC];
        end
    end

    assign preblank_strobe_rise = pin_s[PIN_PREBLANK_STROBE] && !preblank_strobe_d_reg;
    assign fs_rise   = pin_s[PIN_FSYNC] && !fs_d_reg;

    // The software reset pulse only answers to rst_n, so it cannot cut itself short.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            soft_rst_reg <= 1'b0;
            soft_cnt_reg <= 4'h0;
        end else if (reg_wr && reg_addr == REG_RESET && reg_wdata[RST_BIT]) begin
            soft_rst_reg <= 1'b1;
            soft_cnt_reg <= SW_RST_CYC_V - 4'h1;
        end else if (soft_cnt_reg != 4'h0) begin
            soft_cnt_reg <= soft_cnt_reg - 4'h1;
        end else begin
            soft_rst_reg <= 1'b0;
        end
    end

    // Power-down is not a reset source here, so contents survive it.
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            master_gain_reg          <= MASTER_GAIN_RST;
            gain_diff_one_reg        <= DIFF_RST;
            gain_diff_two_reg        <= DIFF_RST;
            gain_diff_three_reg      <= DIFF_RST;
            black_gain_diff_even_reg <= DIFF_RST;
            black_gain_diff_odd_reg  <= DIFF_RST;
            control_reg              <= CONTROL_RST;
            even_pattern_reg         <= EVEN_PAT_RST;
            odd_pattern_reg          <= ODD_PAT_RST;
            offset_code_reg          <= OFFSET_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_MASTER_GAIN:  master_gain_reg          <= reg_wdata;
                REG_DIFF_ONE:     gain_diff_one_reg        <= reg_wdata[DIFF_W-1:0];
                REG_DIFF_TWO:     gain_diff_two_reg        <= reg_wdata[DIFF_W-1:0];
                REG_DIFF_THREE:   gain_diff_three_reg      <= reg_wdata[DIFF_W-1:0];
                REG_BLACK_EVEN:   black_gain_diff_even_reg <= reg_wdata[DIFF_W-1:0];
                REG_BLACK_ODD:    black_gain_diff_odd_reg  <= reg_wdata[DIFF_W-1:0];
                REG_CONTROL:      control_reg              <= reg_wdata;
                REG_EVEN_PATTERN: even_pattern_reg         <= reg_wdata;
                REG_ODD_PATTERN:  odd_pattern_reg          <= reg_wdata;
                REG_OFFSET:       offset_code_reg          <= reg_wdata[OFS_W-1:0];
                default: begin
                end
            endcase
        end
    end

    assign line_parity_mode = control_reg[CTL_MODE_LSB +: 2];
    assign chip_sleep_bit   = control_reg[CTL_CHIP_SLEEP];

    // In sync modes frame sync outranks a pre-blanking edge in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            line_sel_reg <= 1'b0;
        end else if (!line_parity_mode[MODE_SYNC_BIT]) begin
            if (preblank_strobe_rise) begin
                line_sel_reg <= pin_s[PIN_LID];
            end
        end else if (fs_rise) begin
            line_sel_reg <= control_reg[CTL_START_PAR];
        end else if (preblank_strobe_rise && line_parity_mode[MODE_PROG_BIT]) begin
            line_sel_reg <= !line_sel_reg;
        end
    end

    cgs_gain_sel u_gain (
        .ref_clk              (ref_clk),
        .clr                  (clr),
        .mult_gain_en         (control_reg[CTL_MULT_GAIN]),
        .line_sel             (line_sel_reg),
        .preblank             (pin_s[PIN_PREBLANK_STROBE]),
        .calib                (pin_s[PIN_CAL]),
        .master_gain          (master_gain_reg),
        .gain_diff_one        (gain_diff_one_reg),
        .gain_diff_two        (gain_diff_two_reg),
        .gain_diff_three      (gain_diff_three_reg),
        .black_gain_diff_even (black_gain_diff_even_reg),
        .black_gain_diff_odd  (black_gain_diff_odd_reg),
        .even_pattern         (even_pattern_reg),
        .odd_pattern          (odd_pattern_reg),
        .gain_code_reg        (gain_code)
    );

    assign sleeping    = pin_s[PIN_PD] || chip_sleep_bit;
    assign drive_en    = control_reg[CTL_OUT_EN] && !pin_s[PIN_OE_N] && !sleeping;
    assign clamp_now   = control_reg[CTL_OUT_CLAMP] && pin_s[PIN_PREBLANK_STROBE];
    assign offset_wide = {{(BUS_W - OFS_W){1'b0}}, offset_code_reg};

    always_comb begin
        if (clamp_now) begin
            bus_next = offset_wide;
        end else if (control_reg[CTL_FLOOR_CLIP] && adc_data < offset_wide) begin
            bus_next = offset_wide;
        end else begin
            bus_next = adc_data;
        end
    end

    // Data keeps flowing while the drivers are off, so enabling is glitch free.
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            output_bus      <= '0;
            output_bus_oe_n <= 1'b1;
            calib_data      <= '0;
        end else begin
            output_bus      <= bus_next;
            output_bus_oe_n <= !drive_en;
            calib_data      <= adc_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            frontend_off  <= 1'b0;
            converter_off <= 1'b0;
        end else begin
            frontend_off  <= sleeping || control_reg[CTL_FE_SLEEP];
            converter_off <= sleeping || control_reg[CTL_CONV_SLEEP];
        end
    end

    always_comb begin
        rdata_next = '0;
        case (reg_addr)
            REG_MASTER_GAIN:  rdata_next = master_gain_reg;
            REG_DIFF_ONE:     rdata_next = {1'b0, gain_diff_one_reg};
            REG_DIFF_TWO:     rdata_next = {1'b0, gain_diff_two_reg};
            REG_DIFF_THREE:   rdata_next = {1'b0, gain_diff_three_reg};
            REG_BLACK_EVEN:   rdata_next = {1'b0, black_gain_diff_even_reg};
            REG_BLACK_ODD:    rdata_next = {1'b0, black_gain_diff_odd_reg};
            REG_CONTROL:      rdata_next = control_reg;
            REG_EVEN_PATTERN: rdata_next = even_pattern_reg;
            REG_ODD_PATTERN:  rdata_next = odd_pattern_reg;
            REG_OFFSET:       rdata_next = {2'h0, offset_code_reg};
            REG_STATUS: begin
                rdata_next[STS_LINE_SEL] = line_sel_reg;
                rdata_next[STS_SLEEPING] = sleeping;
                rdata_next[STS_DRIVING]  = !output_bus_oe_n;
            end
            default:          rdata_next = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    AST_SLEEP_FLOATS: assert property (@(posedge ref_clk) disable iff (clr)
        sleeping |=> output_bus_oe_n)
        else $error("bus driven while powered down");

    AST_DRIVE_WHEN_ENABLED: assert property (@(posedge ref_clk) disable iff (clr)
        (control_reg[CTL_OUT_EN] && !pin_s[PIN_OE_N] && !sleeping) |=> !output_bus_oe_n)
        else $error("bus not driven although enabled");

    AST_CLAMP_OFFSET: assert property (@(posedge ref_clk) disable iff (clr)
        clamp_now |=> output_bus == {4'h0, $past(offset_code_reg)})
        else $error("clamp did not place the offset on the bus");

    AST_FLOOR_CLIP: assert property (@(posedge ref_clk) disable iff (clr)
        (!clamp_now && control_reg[CTL_FLOOR_CLIP] && adc_data < offset_wide)
        |=> output_bus == $past(offset_wide))
        else $error("low code not clipped to offset");

    AST_CAL_UNCLIPPED: assert property (@(posedge ref_clk) disable iff (clr)
        1'b1 |=> calib_data == $past(adc_data))
        else $error("calibration data altered");

    AST_LINE_ID_LATCH: assert property (@(posedge ref_clk) disable iff (clr)
        (!line_parity_mode[MODE_SYNC_BIT] && preblank_strobe_rise) |=> line_sel_reg == $past(pin_s[PIN_LID]))
        else $error("line id not latched on pre-blanking");

    AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (clr)
        (line_parity_mode == 2'h3 && preblank_strobe_rise && !fs_rise) |=> line_sel_reg != $past(line_sel_reg))
        else $error("line flag did not toggle");

    AST_FRAME_PRESET: assert property (@(posedge ref_clk) disable iff (clr)
        (line_parity_mode[MODE_SYNC_BIT] && fs_rise)
        |=> line_sel_reg == $past(control_reg[CTL_START_PAR]))
        else $error("frame sync did not preset the line flag");

    AST_SOFT_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == REG_RESET && reg_wdata[RST_BIT])
        |=> soft_rst_reg ##1 (!soft_rst_reg && master_gain_reg == MASTER_GAIN_RST))
        else $error("software reset pulse wrong");

    AST_SLEEP_RETAINS: assert property (@(posedge ref_clk) disable iff (clr)
        (sleeping && !reg_wr) |=> $stable(master_gain_reg) && $stable(control_reg))
        else $error("register changed during power-down");

    COV_CLAMP:  cover property (@(posedge ref_clk) disable iff (clr) clamp_now && drive_en);
    COV_CLIP:   cover property (@(posedge ref_clk) disable iff (clr)
        !clamp_now && control_reg[CTL_FLOOR_CLIP] && adc_data < offset_wide);
    COV_TOGGLE: cover property (@(posedge ref_clk) disable iff (clr)
        line_parity_mode == 2'h3 && preblank_strobe_rise);
    COV_SLEEP:  cover property (@(posedge ref_clk) disable iff (clr) sleeping ##1 !sleeping);

endmodule : cgs_ctrl

//--- dv/cgs_tgen.sv
/*
 * Timing generator model: line-id level, pre-blanking pulses, frame sync.
 * Assumes the bench calls its tasks from one process at a time.
 */
module cgs_tgen (
    input  wire logic ref_clk,
    output logic      line_id_input,
    output logic      preblank_strobe,
    output logic      frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        line_id_input   = 1'b0;
        preblank_strobe = 1'b0;
        frame_sync      = 1'b0;
    end

    // Line id is held over the whole pulse so the latching edge sees it settled.
    task automatic pulse_line(input logic lid);
        @(posedge ref_clk);
        line_id_input   <= lid;
        preblank_strobe <= 1'b1;
        repeat (8) @(posedge ref_clk);
        preblank_strobe <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : pulse_line

    task automatic pulse_frame();
        @(posedge ref_clk);
        frame_sync <= 1'b1;
        repeat (8) @(posedge ref_clk);
        frame_sync <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : pulse_frame
endmodule : cgs_tgen

//--- dv/cgs_ctrl_bench.sv
/*
 * Self-checking bench for cgs_ctrl with the timing generator model.
 * Assumes the register port and pin latencies given by the designer.
 */
module cgs_ctrl_bench
    import cgs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 10'h000, v, m;
    logic              powerdown_pin = 1'b0, output_enable_n_pin = 1'b0, cal_strobe = 1'b0;
    logic [BUS_W-1:0]  adc_data = 12'h000, adc;
    logic              line_id_input, preblank_strobe, frame_sync;
    logic [DATA_W-1:0] reg_rdata;
    logic [BUS_W-1:0]  output_bus, calib_data;
    logic [MG_W-1:0]   gain_code;
    logic              output_bus_oe_n, frontend_off, converter_off;
    logic [31:0]       seed = 32'hc71d;
    logic [8:0]        d;
    logic [7:0]        ofs;
    int                err_count = 0, n_checks = 0, cycles = 0;
    localparam logic [9:0] RST_TAB [10] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
                                           10'h000, 10'h038, 10'h005, 10'h021, 10'h000};

    cgs_tgen tg (.ref_clk(ref_clk), .line_id_input(line_id_input),
                 .preblank_strobe(preblank_strobe), .frame_sync(frame_sync));
    cgs_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .powerdown_pin(powerdown_pin),
        .output_enable_n_pin(output_enable_n_pin), .line_id_input(line_id_input),
        .preblank_strobe(preblank_strobe), .frame_sync(frame_sync), .cal_strobe(cal_strobe),
        .adc_data(adc_data), .output_bus(output_bus), .output_bus_oe_n(output_bus_oe_n),
        .calib_data(calib_data), .gain_code(gain_code), .frontend_off(frontend_off),
        .converter_off(converter_off));

    always #5 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // A difference larger than the master gain saturates at zero.
    function automatic logic [11:0] exp_gain(input logic [9:0] mg, input logic [8:0] df);
        return (df > mg) ? 12'h000 : {2'b00, mg - {1'b0, df}};
    endfunction : exp_gain
    function automatic logic [11:0] exp_out(input logic [11:0] a, input logic [7:0] o,
                                           input logic clip);
        return (clip && a < {4'h0, o}) ? {4'h0, o} : a;
    endfunction : exp_out

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk_bus(input logic [11:0] g, input logic [11:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_bus
    task automatic wr(input logic [3:0] a, input logic [9:0] dat);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_n
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        wait_n(2);
        v = reg_rdata;
    endtask : rd
    task automatic rchk(input logic [3:0] a, input logic [9:0] e);
        rd(a);
        chk_bus({2'b00, v}, {2'b00, e});
    endtask : rchk

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rchk(4'(i), RST_TAB[i]);
        wr(REG_DIFF_ONE, 10'h3ff);
        rchk(REG_DIFF_ONE, 10'h1ff);
        wr(REG_MASTER_GAIN, 10'h3ff);
        rchk(REG_MASTER_GAIN, 10'h3ff);
        wr(REG_EVEN_PATTERN, 10'h004);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(lfsr(seed));
            m = (i == 0) ? 10'h010 : seed[9:0];
            d = (i == 0) ? 9'h1ff : seed[18:10];
            ofs = seed[26:19] | 8'h01;
            adc = (i == 2) ? 12'h000 : {seed[31:27], seed[6:0]};
            wr(REG_CONTROL, i[0] ? 10'h228 : 10'h238);
            wr(REG_MASTER_GAIN, m);
            wr(REG_DIFF_ONE, {1'b0, d});
            wr(REG_OFFSET, {2'b00, ofs});
            @(posedge ref_clk) adc_data <= adc;
            wait_n(4);
            chk_bus({2'b00, gain_code}, exp_gain(m, d));
            chk_bus(output_bus, exp_out(adc, ofs, !i[0]));
            chk_bus(calib_data, adc);
        end
        // Black pixels on an even line take the even black difference, not the colour one.
        wr(REG_BLACK_EVEN, {1'b0, ~d});
        @(posedge ref_clk) cal_strobe <= 1'b1;
        wait_n(4);
        chk_bus({2'b00, gain_code}, exp_gain(m, ~d));
        @(posedge ref_clk) cal_strobe <= 1'b0;
        wr(REG_CONTROL, 10'h038);
        fork
            tg.pulse_line(1'b0);
            begin wait_n(6); chk_bus(output_bus, {4'h0, ofs}); end
        join
        tg.pulse_line(1'b1);
        rd(REG_STATUS);
        chk_bus({11'h0, v[0]}, 12'h001);
        wr(REG_CONTROL, 10'h0f8);
        tg.pulse_frame();
        rd(REG_STATUS);
        chk_bus({11'h0, v[0]}, 12'h000);
        tg.pulse_line(1'b0);
        rd(REG_STATUS);
        chk_bus({11'h0, v[0]}, 12'h001);
        // Interlaced sync mode: pre-blanking neither toggles nor latches the line id.
        wr(REG_CONTROL, 10'h0b8);
        tg.pulse_line(1'b0);
        rd(REG_STATUS);
        chk_bus({11'h0, v[0]}, 12'h001);
        tg.pulse_frame();
        rd(REG_STATUS);
        chk_bus({11'h0, v[0]}, 12'h000);
        @(posedge ref_clk) powerdown_pin <= 1'b1;
        wait_n(5);
        chk_bus({11'h0, output_bus_oe_n}, 12'h001);
        rchk(REG_MASTER_GAIN, m);
        @(posedge ref_clk) powerdown_pin <= 1'b0;
        wait_n(5);
        chk_bus({11'h0, output_bus_oe_n}, 12'h000);
        wr(REG_CONTROL, 10'h0f9);
        wait_n(3);
        chk_bus({11'h0, output_bus_oe_n}, 12'h001);
        wr(REG_CONTROL, 10'h036);
        wait_n(3);
        chk_bus({9'h0, frontend_off, converter_off, output_bus_oe_n}, 12'h007);
        wr(REG_CONTROL, 10'h038);
        @(posedge ref_clk) output_enable_n_pin <= 1'b1;
        adc_data <= 12'h123;
        wait_n(5);
        chk_bus({11'h0, output_bus_oe_n}, 12'h001);
        chk_bus(calib_data, 12'h123);
        wr(4'hc, 10'h155);
        rchk(4'hc, 10'h000);
        wr(REG_OFFSET, 10'h0ff);
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(REG_OFFSET, 10'h000);
        wr(REG_MASTER_GAIN, 10'h2aa);
        wr(REG_RESET, 10'h001);
        wait_n(3);
        rchk(REG_MASTER_GAIN, 10'h000);
        rchk(REG_CONTROL, 10'h038);
        end_of_test();
    end
endmodule : cgs_ctrl_bench
